// >>> common/ispp_defines.svh
/*
 constants for the pixel port: frame geometry, blanking, strap bit positions.
 assumes one master clock domain plus one stereo shift clock domain.
*/
`ifndef ISPP_DEFINES_SVH
`define ISPP_DEFINES_SVH
`define ISPP_PIX_W 10
`define ISPP_RAW_W 12
`define ISPP_COLS 10'h2F0
`define ISPP_ROWS 9'h1E0
`define ISPP_HBLANK 10'h05E
`define ISPP_VBLANK_ROWS 9'h02D
`define ISPP_CNT_W 10
`define ISPP_ROW_W 9
`define ISPP_ADDR_BASE 7'h48
`define ISPP_ADDR_BIT_LO 3
`define ISPP_ADDR_BIT_HI 5
`define ISPP_COMP_KNEE 12'h200
`define ISPP_SER_W 4
`define ISPP_SER_LAST 4'hB
`endif

// >>> common/ispp_pkg.sv
/*
 types for the pixel port.
 assumes ispp_defines.svh is on the include path.
*/
`include "ispp_defines.svh"
package ispp_pkg;
    typedef enum logic [1:0] {
        ISPP_IDLE = 2'b00,
        ISPP_WAIT_TRIG = 2'b01,
        ISPP_ACTIVE = 2'b10,
        ISPP_VBLANK = 2'b11
    } ispp_state_t;
endpackage

// >>> rtl/ispp_image_sensor_pixel_port.sv
/*
 pixel port of the image sensor: timing generator, parallel output,
 syncs, companding, straps and stereo serial merge.
 assumes straps are static, the partner samples data on pixel clock rise.
*/
`timescale 1ns/100ps
`default_nettype none
`include "ispp_defines.svh"
// Function
// - slave mode: trigger rising edge starts integration
// - output enable high drives data, else released
// - only data lines follow output enable
// - low strap sets address bit three
// - high strap sets address bit five
// - low reset clears all state immediately
// - standby halts operation and readout
// - line sync output master, input slave
// - frame sync output master, input slave
// - valids high only during active data
// - data valid at pixel clock rise
// - pixels output with ten bits
// - optional companding twelve to ten bits
// - stereo master merges both streams serially
// - defaults give full frames continuously
// - active image 752 by 480
// - binning, windowing and mirroring supported
// - one word per pixel clock during line
// - pixel clock inverted master, always toggling
module ispp_image_sensor_pixel_port
    import ispp_pkg::*;
(
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic clk_en_in,
    input wire logic reset_n_in,
    input wire logic standby_in,
    input wire logic slave_mode_in,
    input wire logic trigger_in,
    input wire logic output_enable_in,
    input wire logic address_strap_low,
    input wire logic address_strap_high,
    input wire logic compand_en_in,
    input wire logic [1:0] bin_sel_in,
    input wire logic mirror_col_in,
    input wire logic mirror_row_in,
    input wire logic [9:0] win_cols_in,
    input wire logic [8:0] win_rows_in,
    input wire logic [11:0] raw_pixel_in,
    input wire logic line_start_sync_in,
    input wire logic frame_start_sync_in,
    input wire logic stereo_master_in,
    input wire logic stereo_shift_clock_in_pos,
    input wire logic stereo_shift_clock_in_neg,
    input wire logic stereo_serial_in_pos,
    input wire logic stereo_serial_in_neg,
    output logic [9:0] pixel_data_out,
    output logic pixel_data_oe_out,
    output logic pixel_out_clock,
    output logic line_valid_out,
    output logic frame_valid_out,
    output logic line_start_sync_out,
    output logic line_start_sync_oe_out,
    output logic frame_start_sync_out,
    output logic frame_start_sync_oe_out,
    output logic integrating_out,
    output logic [9:0] read_col_out,
    output logic [8:0] read_row_out,
    output logic [6:0] slave_address_out,
    output logic strobe_output,
    output logic serial_stream_out_pos,
    output logic serial_stream_out_neg,
    output logic serial_shift_clock_out_pos,
    output logic serial_shift_clock_out_neg
);
    // ****************************************
    // reset and pin synchronisers
    // ****************************************
    logic rst;
    logic [2:0] trig_sy_ff, nxt_trig_sy;
    logic [2:0] lsy_sy_ff, nxt_lsy_sy;
    logic [2:0] fsy_sy_ff, nxt_fsy_sy;
    logic trig_st_ff, nxt_trig_st;
    logic lsy_st_ff, nxt_lsy_st;
    logic fsy_st_ff, nxt_fsy_st;
    // async low reset collapses into the common reset term
    assign rst = reset_in | ~reset_n_in;

    always_comb begin
        nxt_trig_sy = {trig_sy_ff[1:0], trigger_in};
        nxt_lsy_sy = {lsy_sy_ff[1:0], line_start_sync_in};
        nxt_fsy_sy = {fsy_sy_ff[1:0], frame_start_sync_in};
        nxt_trig_st = (trig_sy_ff[2] == trig_sy_ff[1]) ? trig_sy_ff[2] : trig_st_ff;
        nxt_lsy_st = (lsy_sy_ff[2] == lsy_sy_ff[1]) ? lsy_sy_ff[2] : lsy_st_ff;
        nxt_fsy_st = (fsy_sy_ff[2] == fsy_sy_ff[1]) ? fsy_sy_ff[2] : fsy_st_ff;
    end

    always_ff @(posedge clk_in or posedge rst) begin
        if (rst) begin
            trig_sy_ff <= 3'h0;
            lsy_sy_ff <= 3'h0;
            fsy_sy_ff <= 3'h0;
            trig_st_ff <= 1'b0;
            lsy_st_ff <= 1'b0;
            fsy_st_ff <= 1'b0;
        end else if (clk_en_in) begin
            trig_sy_ff <= nxt_trig_sy;
            lsy_sy_ff <= nxt_lsy_sy;
            fsy_sy_ff <= nxt_fsy_sy;
            trig_st_ff <= nxt_trig_st;
            lsy_st_ff <= nxt_lsy_st;
            fsy_st_ff <= nxt_fsy_st;
        end
    end

    logic trig_rise, lsy_rise, fsy_rise;
    assign trig_rise = nxt_trig_st & ~trig_st_ff;
    assign lsy_rise = nxt_lsy_st & ~lsy_st_ff;
    assign fsy_rise = nxt_fsy_st & ~fsy_st_ff;

    // ****************************************
    // straps
    // ****************************************
    always_comb begin
        slave_address_out = `ISPP_ADDR_BASE;
        slave_address_out[`ISPP_ADDR_BIT_LO] = address_strap_low;
        slave_address_out[`ISPP_ADDR_BIT_HI] = address_strap_high;
    end

    // ****************************************
    // frame timing generator
    // ****************************************
    ispp_state_t state_ff, nxt_state;
    logic [9:0] col_ff, nxt_col;
    logic [8:0] row_ff, nxt_row;
    logic [1:0] bin_ff, nxt_bin;
    logic [9:0] line_len;
    logic [8:0] frame_rows;
    logic in_line, step, line_end, frame_end, slave_sync_line;

    // zero window means full frame, so defaults need no programming
    assign line_len = (win_cols_in == 10'h000) ? `ISPP_COLS : win_cols_in;
    assign frame_rows = (win_rows_in == 9'h000) ? `ISPP_ROWS : win_rows_in;
    assign in_line = (col_ff < line_len);
    assign step = (bin_ff == bin_sel_in);
    assign line_end = step & (col_ff == line_len + `ISPP_HBLANK - 10'h001);
    assign frame_end = line_end & (row_ff == frame_rows - 9'h001);
    assign slave_sync_line = slave_mode_in & lsy_rise;

    always_comb begin
        nxt_state = state_ff;
        nxt_col = col_ff;
        nxt_row = row_ff;
        nxt_bin = step ? 2'h0 : bin_ff + 2'h1;
        unique case (state_ff)
            ISPP_IDLE: begin
                nxt_col = 10'h000;
                nxt_row = 9'h000;
                if (slave_mode_in) begin
                    nxt_state = ISPP_WAIT_TRIG;
                end else begin
                    nxt_state = ISPP_ACTIVE;
                end
            end
            ISPP_WAIT_TRIG: begin
                nxt_col = 10'h000;
                nxt_row = 9'h000;
                if (trig_rise | fsy_rise) begin
                    nxt_state = ISPP_ACTIVE;
                end
            end
            ISPP_ACTIVE: begin
                if (slave_sync_line) begin
                    nxt_col = 10'h000;
                end else if (frame_end) begin
                    nxt_col = 10'h000;
                    nxt_row = 9'h000;
                    nxt_state = ISPP_VBLANK;
                end else if (line_end) begin
                    nxt_col = 10'h000;
                    nxt_row = row_ff + 9'h001;
                end else if (step) begin
                    nxt_col = col_ff + 10'h001;
                end
            end
            ISPP_VBLANK: begin
                if (line_end) begin
                    nxt_col = 10'h000;
                    nxt_row = row_ff + 9'h001;
                    if (row_ff == `ISPP_VBLANK_ROWS - 9'h001) begin
                        nxt_row = 9'h000;
                        nxt_state = slave_mode_in ? ISPP_WAIT_TRIG : ISPP_ACTIVE;
                    end
                end else if (step) begin
                    nxt_col = col_ff + 10'h001;
                end
            end
        endcase
    end

    always_ff @(posedge clk_in or posedge rst) begin
        if (rst) begin
            state_ff <= ISPP_IDLE;
            col_ff <= 10'h000;
            row_ff <= 9'h000;
            bin_ff <= 2'h0;
        end else if (clk_en_in & ~standby_in) begin
            state_ff <= nxt_state;
            col_ff <= nxt_col;
            row_ff <= nxt_row;
            bin_ff <= nxt_bin;
        end
    end

    // ****************************************
    // pixel output stage
    // ****************************************
    logic [9:0] pix_ff, nxt_pix;
    logic lv_ff, nxt_lv, fv_ff, nxt_fv, lso_ff, nxt_lso, fso_ff, nxt_fso, integ_ff, nxt_integ;
    logic [9:0] comp_code;
    logic [9:0] rcol_ff, nxt_rcol;
    logic [8:0] rrow_ff, nxt_rrow;

    // knee keeps fine steps for dark signals, coarse for bright
    always_comb begin
        if (raw_pixel_in < `ISPP_COMP_KNEE) begin
            comp_code = raw_pixel_in[9:0];
        end else begin
            comp_code = 10'h200 + {3'h0, 7'(({1'b0, raw_pixel_in} - {1'b0, `ISPP_COMP_KNEE}) >> 5)};
        end
    end

    always_comb begin
        nxt_lv = (state_ff == ISPP_ACTIVE) & in_line & ~standby_in;
        nxt_fv = (state_ff == ISPP_ACTIVE) & ~standby_in;
        nxt_pix = 10'h000;
        if (nxt_lv) begin
            nxt_pix = compand_en_in ? comp_code : raw_pixel_in[11:2];
        end
        nxt_rcol = mirror_col_in ? line_len - 10'h001 - col_ff : col_ff;
        nxt_rrow = mirror_row_in ? frame_rows - 9'h001 - row_ff : row_ff;
        nxt_lso = ~slave_mode_in & (state_ff == ISPP_ACTIVE) & (col_ff == 10'h000);
        nxt_fso = ~slave_mode_in & (state_ff == ISPP_ACTIVE) & (col_ff == 10'h000)
            & (row_ff == 9'h000);
        nxt_integ = trig_rise & slave_mode_in ? 1'b1 : (integ_ff & ~nxt_fv);
    end

    always_ff @(posedge clk_in or posedge rst) begin
        if (rst) begin
            pix_ff <= 10'h000;
            lv_ff <= 1'b0;
            fv_ff <= 1'b0;
            lso_ff <= 1'b0;
            fso_ff <= 1'b0;
            integ_ff <= 1'b0;
            rcol_ff <= 10'h000;
            rrow_ff <= 9'h000;
        end else if (clk_en_in) begin
            pix_ff <= nxt_pix;
            lv_ff <= nxt_lv;
            fv_ff <= nxt_fv;
            lso_ff <= nxt_lso;
            fso_ff <= nxt_fso;
            integ_ff <= nxt_integ;
            rcol_ff <= nxt_rcol;
            rrow_ff <= nxt_rrow;
        end
    end

    // data changes on clk rise, which is the pixel clock fall
    assign pixel_out_clock = ~clk_in;
    assign pixel_data_out = pix_ff;
    assign pixel_data_oe_out = output_enable_in;
    assign line_valid_out = lv_ff;
    assign frame_valid_out = fv_ff;
    assign line_start_sync_out = lso_ff;
    assign line_start_sync_oe_out = ~slave_mode_in;
    assign frame_start_sync_out = fso_ff;
    assign frame_start_sync_oe_out = ~slave_mode_in;
    assign integrating_out = integ_ff;
    assign read_col_out = rcol_ff;
    assign read_row_out = rrow_ff;
    assign strobe_output = integ_ff;

    // ****************************************
    // stereo serial merge
    // ****************************************
    // word toggles into the shift domain; slave bits come back on that clock
    logic tog_ff, nxt_tog;
    logic [9:0] hold_ff, nxt_hold;
    always_comb begin
        nxt_tog = tog_ff ^ lv_ff;
        nxt_hold = lv_ff ? pix_ff : hold_ff;
    end
    always_ff @(posedge clk_in or posedge rst) begin
        if (rst) begin
            tog_ff <= 1'b0;
            hold_ff <= 10'h000;
        end else if (clk_en_in) begin
            tog_ff <= nxt_tog;
            hold_ff <= nxt_hold;
        end
    end

    logic [2:0] stog_ff, nxt_stog;
    logic [3:0] bit_ff, nxt_bit;
    logic [11:0] shreg_ff, nxt_shreg;
    logic sout_ff, nxt_sout;
    always_comb begin
        nxt_stog = {stog_ff[1:0], tog_ff};
        nxt_bit = bit_ff;
        nxt_shreg = {shreg_ff[10:0], 1'b0};
        nxt_sout = shreg_ff[11];
        if (stog_ff[2] != stog_ff[1]) begin
            nxt_bit = 4'h0;
            nxt_shreg = {1'b1, hold_ff, 1'b0};
        end else if (bit_ff != `ISPP_SER_LAST) begin
            nxt_bit = bit_ff + 4'h1;
        end
        // own bits interleaved with the received slave bits
        if (stereo_master_in & bit_ff[0]) begin
            nxt_sout = stereo_serial_in_pos & ~stereo_serial_in_neg;
        end
    end
    always_ff @(posedge stereo_shift_clock_in_pos or posedge rst) begin
        if (rst) begin
            stog_ff <= 3'h0;
            bit_ff <= 4'h0;
            shreg_ff <= 12'h000;
            sout_ff <= 1'b0;
        end else begin
            stog_ff <= nxt_stog;
            bit_ff <= nxt_bit;
            shreg_ff <= nxt_shreg;
            sout_ff <= nxt_sout;
        end
    end
    assign serial_stream_out_pos = sout_ff;
    assign serial_stream_out_neg = ~sout_ff;
    assign serial_shift_clock_out_pos = stereo_shift_clock_in_pos;
    assign serial_shift_clock_out_neg = ~stereo_shift_clock_in_pos;

    // ****************************************
    // checks
    // ****************************************
    AST_LV_IN_FV: assert property (@(posedge clk_in) disable iff (rst)
        line_valid_out |-> frame_valid_out) else $error("line valid outside frame");
    AST_BLANK_ZERO: assert property (@(posedge clk_in) disable iff (rst)
        !line_valid_out |-> pixel_data_out == 10'h000) else $error("data in blanking");
    AST_OE: assert property (@(posedge clk_in) disable iff (rst)
        pixel_data_oe_out == output_enable_in) else $error("oe mismatch");
    AST_SYNC_OE: assert property (@(posedge clk_in) disable iff (rst)
        slave_mode_in |-> !line_start_sync_oe_out && !frame_start_sync_oe_out)
        else $error("slave drives sync");
    AST_ADDR: assert property (@(posedge clk_in) disable iff (rst)
        slave_address_out[3] == address_strap_low && slave_address_out[5] == address_strap_high)
        else $error("strap address wrong");
    AST_STANDBY: assert property (@(posedge clk_in) disable iff (rst)
        standby_in && clk_en_in |=> !line_valid_out) else $error("readout in standby");
    AST_SLAVE_WAIT: assert property (@(posedge clk_in) disable iff (rst)
        state_ff == ISPP_WAIT_TRIG && !trig_rise && !fsy_rise |=> state_ff != ISPP_ACTIVE)
        else $error("slave started untriggered");
    AST_FSO_FV: assert property (@(posedge clk_in) disable iff (rst)
        frame_start_sync_out |-> frame_valid_out) else $error("frame sync outside frame");
    AST_COL_STEP: assert property (@(posedge clk_in) disable iff (rst)
        clk_en_in && !standby_in && state_ff == ISPP_ACTIVE && step && !line_end
        && !slave_sync_line |=> col_ff == $past(col_ff) + 10'h001)
        else $error("column not advancing");
endmodule
`default_nettype wire

// >>> verif/ispp_capture_model.sv
/*
 capture logic at the far side of the pixel port: counts words per line.
 assumes pixel data is sampled on pixel clock rise, valids as qualifiers.
*/
`timescale 1ns/100ps
`default_nettype none
module ispp_capture_model (
    input wire logic pixel_out_clock,
    input wire logic line_valid_in,
    input wire logic frame_valid_in,
    input wire logic [9:0] pixel_data_in,
    output logic [9:0] line_words_out,
    output logic [9:0] last_word_out
);
    logic [9:0] cnt_ff = 10'h000;
    // ***********************************
    // capture
    // ***********************************
    always @(posedge pixel_out_clock) begin
        if (line_valid_in && frame_valid_in) begin
            cnt_ff <= cnt_ff + 10'h001;
            last_word_out <= pixel_data_in;
        end else if (cnt_ff != 10'h000) begin
            // blanking samples dropped, line length kept
            line_words_out <= cnt_ff;
            cnt_ff <= 10'h000;
        end
    end
endmodule
`default_nettype wire

// >>> verif/tb_top.sv
/*
 self-checking bench for the pixel port with a capture model.
 assumes a 16 by 4 window keeps frames short.
*/
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    import ispp_pkg::*;
    typedef struct {logic lo; logic hi; logic oe; logic [6:0] adr;} ispp_row_t;
    logic clk_in = 1'b0, reset_in = 1'b1, reset_n_in = 1'b1, standby_in = 1'b0;
    logic slave_mode_in = 1'b0, trigger_in = 1'b0, oe_in = 1'b1, lo = 1'b0, hi = 1'b0;
    logic compand_en_in = 1'b0, fsync_in = 1'b0, lnk = 1'b0, lnk_run = 1'b0;
    logic ser_in = 1'b0, stereo_master_in = 1'b0, clk_en = 1'b1, lsync = 1'b0;
    logic [11:0] raw = 12'hABC;
    logic [9:0] pix, words, last;
    logic [6:0] adr;
    logic pclk, lv, fv, lso, lso_oe, fso, fso_oe, integ, pix_oe, sck;
    int n_fail = 0, total_checks = 0;
    ispp_row_t rows [4] = '{'{1'b0, 1'b0, 1'b1, 7'h40}, '{1'b1, 1'b0, 1'b0, 7'h48},
        '{1'b0, 1'b1, 1'b1, 7'h60}, '{1'b1, 1'b1, 1'b0, 7'h68}};
    ispp_image_sensor_pixel_port dut (.clk_in(clk_in), .reset_in(reset_in), .clk_en_in(clk_en),
        .reset_n_in(reset_n_in), .standby_in(standby_in), .slave_mode_in(slave_mode_in),
        .trigger_in(trigger_in), .output_enable_in(oe_in), .address_strap_low(lo),
        .address_strap_high(hi), .compand_en_in(compand_en_in), .bin_sel_in(2'h0),
        .mirror_col_in(1'b0), .mirror_row_in(1'b0), .win_cols_in(10'h010),
        .win_rows_in(9'h004), .raw_pixel_in(raw), .line_start_sync_in(lsync),
        .frame_start_sync_in(fsync_in), .stereo_master_in(stereo_master_in),
        .stereo_shift_clock_in_pos(lnk), .stereo_shift_clock_in_neg(~lnk),
        .stereo_serial_in_pos(ser_in), .stereo_serial_in_neg(~ser_in),
        .pixel_data_out(pix), .pixel_data_oe_out(pix_oe), .pixel_out_clock(pclk),
        .line_valid_out(lv), .frame_valid_out(fv), .line_start_sync_out(lso),
        .line_start_sync_oe_out(lso_oe), .frame_start_sync_out(fso),
        .frame_start_sync_oe_out(fso_oe), .integrating_out(integ), .read_col_out(),
        .read_row_out(), .slave_address_out(adr), .strobe_output(),
        .serial_stream_out_pos(), .serial_stream_out_neg(),
        .serial_shift_clock_out_pos(sck), .serial_shift_clock_out_neg());
    ispp_capture_model cap (.pixel_out_clock(pclk), .line_valid_in(lv),
        .frame_valid_in(fv), .pixel_data_in(pix), .line_words_out(words),
        .last_word_out(last));
    // ***********************************
    // clocks
    // ***********************************
    initial begin
        forever #20 clk_in = ~clk_in;
    end
    // link clock unrelated in phase, held still outside stereo traffic
    initial begin
        #7;
        forever begin
            #80;
            if (lnk_run) begin
                lnk = ~lnk;
                if (!lnk) begin
                    ser_in = ~ser_in;
                end
            end
        end
    end
    // ***********************************
    // helpers
    // ***********************************
    task automatic tick(input int n);
        repeat (n) @(posedge clk_in);
    endtask
    task automatic chk(input string what, input logic [9:0] exp, input logic [9:0] got);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask
    function automatic logic pick(input int which);
        return which == 0 ? lv : (which == 1 ? fv : integ);
    endfunction
    task automatic waitv(input int which, input logic lvl, input int lim);
        int i;
        for (i = 0; i < lim; i++) begin
            tick(1);
            #2;
            if (pick(which) === lvl) begin
                return;
            end
        end
        chk("wait", {9'h000, lvl}, {9'h000, pick(which)});
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (60000) @(posedge clk_in);
        n_fail++;
        test_done();
    end
    // ***********************************
    // tests
    // ***********************************
    initial begin
        tick(3);
        reset_in <= 1'b0;
        foreach (rows[i]) begin
            tick(1);
            lo <= rows[i].lo;
            hi <= rows[i].hi;
            oe_in <= rows[i].oe;
            tick(1);
            #2;
            chk("address", {3'h0, rows[i].adr}, {3'h0, adr});
            chk("data enable", {9'h000, rows[i].oe}, {9'h000, pix_oe});
            chk("pixel clock", {9'h000, ~clk_in}, {9'h000, pclk});
            chk("valid drive", 10'h000, {9'h000, $isunknown(lv)});
        end
        $display("test table done");
        tick(1);
        oe_in <= 1'b1;
        waitv(0, 1'b0, 200);
        waitv(0, 1'b1, 200);
        chk("frame valid", 10'h001, {9'h000, fv});
        chk("pixel", 10'h2AF, pix);
        chk("line sync drive", 10'h001, {9'h000, lso_oe});
        waitv(0, 1'b0, 40);
        tick(2);
        #2;
        chk("line words", 10'h010, words);
        chk("last word", 10'h2AF, last);
        $display("test line done");
        waitv(1, 1'b0, 600);
        waitv(1, 1'b1, 6000);
        chk("frame sync", 10'h001, {9'h000, fso});
        chk("frame line valid", 10'h001, {9'h000, lv});
        $display("test frame done");
        tick(1);
        compand_en_in <= 1'b1;
        raw <= 12'h100;
        waitv(0, 1'b0, 40);
        waitv(0, 1'b1, 200);
        tick(1);
        #2;
        chk("companded", 10'h100, pix);
        $display("test compand done");
        tick(1);
        standby_in <= 1'b1;
        tick(3);
        #2;
        chk("standby line", 10'h000, {9'h000, lv});
        chk("standby frame", 10'h000, {9'h000, fv});
        chk("standby clock", {9'h000, ~clk_in}, {9'h000, pclk});
        tick(1);
        standby_in <= 1'b0;
        waitv(0, 1'b1, 6000);
        // reset pin is asynchronous, so it is moved between edges on purpose
        #5 reset_n_in = 1'b0;
        #2;
        chk("async reset", 10'h000, {9'h000, lv});
        tick(2);
        reset_n_in <= 1'b1;
        $display("test reset done");
        slave_mode_in <= 1'b1;
        stereo_master_in <= 1'b1;
        lnk_run <= 1'b1;
        tick(12);
        #2;
        chk("slave idle", 10'h000, {9'h000, fv});
        chk("line sync input", 10'h000, {9'h000, lso_oe});
        chk("frame sync input", 10'h000, {9'h000, fso_oe});
        chk("shift clock", {9'h000, lnk}, {9'h000, sck});
        tick(1);
        trigger_in <= 1'b1;
        waitv(2, 1'b1, 10);
        tick(1);
        trigger_in <= 1'b0;
        fsync_in <= 1'b1;
        tick(2);
        fsync_in <= 1'b0;
        waitv(1, 1'b1, 20);
        lnk_run <= 1'b0;
        $display("test slave done");
        test_done();
    end
endmodule
`default_nettype wire
